// ---- include/wdtp_pkg.sv ----
// Purpose: Shared constants and types of the watchdog with prescaler.
// Assumes: One clock, pclk, which stands in for the x4 oscillator clock.
// Notes:   Register indices are word indices; byte address is four times.

package wdtp_pkg;

	// APB address width: index 16'hFFFF times four needs 18 bits.
	localparam int unsigned ADDR_W = 18;
	localparam int unsigned IDX_W  = 16;

	// Register indices.
	localparam logic [IDX_W-1:0] CLEAR_IDX   = 16'hFFFF;
	localparam logic [IDX_W-1:0] CFG_IDX     = 16'h0010;
	localparam logic [IDX_W-1:0] CAUSE_IDX   = 16'h0011;
	localparam logic [IDX_W-1:0] EVT_IDX     = 16'h0012;
	localparam logic [IDX_W-1:0] EVT_CLR_IDX = 16'h0013;
	localparam logic [IDX_W-1:0] EVT_EN_IDX  = 16'h0014;

	// Field positions.
	localparam int unsigned CFG_DIS_BIT    = 0;
	localparam int unsigned CFG_RATE_BIT   = 1;
	localparam int unsigned CFG_LOCK_BIT   = 2;
	localparam int unsigned CAUSE_WD_BIT   = 0;
	localparam int unsigned EVT_TMO_BIT    = 0;
	localparam int unsigned EVT_REJECT_BIT = 1;
	localparam int unsigned EVT_W          = 2;

	// Counter structure.
	localparam int unsigned PRE_W = 12;
	localparam int unsigned WD_W  = 6;
	localparam int unsigned CNT_W = PRE_W + WD_W;
	// Lowest prescaler stage cleared by a service write (stage 5).
	localparam int unsigned PRE_CLR_LO = 4;

	// Cycle counts.
	localparam int unsigned RST_HOLD_CYC = 32;
	localparam int unsigned POR_CYC      = 4096;

	// Values after reset.
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
	localparam logic             CFG_RST = 1'h0;

	typedef enum logic [2:0] {
		WDTP_POR = 3'h1,
		WDTP_RUN = 3'h2,
		WDTP_RST = 3'h4
	} wdtp_state_t;

	// Operating mode inputs, all from logic on pclk.
	typedef struct packed {
		logic internal_reset;
		logic stop_mode;
		logic stop_instr;
		logic monitor_mode;
		logic break_active;
		logic break_watchdog_disable;
	} wdtp_mode_t;

	typedef struct packed {
		wdtp_state_t      state;
		logic [PRE_W-1:0] pre;
		logic [WD_W-1:0]  wd;
		logic [4:0]       rst_cnt;
		logic [11:0]      por_cnt;
		logic             pin_drive;
		logic             cfg_dis;
		logic             cfg_rate;
		logic             cfg_lock;
		logic             cause_wd;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_en;
		logic             tst_s1;
		logic             tst_s2;
		logic [31:0]      prdata;
	} wdtp_regs_t;

endpackage

// ---- hw/wdtp_top.sv ----
// Purpose: Watchdog with 12-bit prescaler and 6-bit counter, APB slave.
// Assumes: pclk is the x4 oscillator clock; mode inputs are on pclk.
// Notes:   The watchdog reset output and pin drive last a fixed hold time.
//
// Implementation choice: the APB interface to the registers.

`timescale 1ns/1ns

// Overview of operation
// - Six-bit counter chained behind twelve-bit prescaler.
// - Unserviced watchdog resets after selected timeout.
// - Rate one short timeout, zero long.
// - Any clear-port write zeroes counter, stages twelve-five.
// - Clear-port read returns vector low byte.
// - Timeout drives reset pin, sets cause flag.
// - Stop instruction clears the prescaler.
// - Power-up clears prescaler after 4096 cycles.
// - Internal reset clears prescaler and counter.
// - Disable bit live: one off, zero on.
// - Watchdog never raises a CPU interrupt.
// - Monitor mode with test voltage disables.
// - Counting continues in wait; software services.
// - Stop mode freezes counter, clears prescaler.
// - Break with disable bit in monitor disables.
// - Configuration accepts one write per reset.
module wdtp_top #(
	parameter int unsigned LONG_TIMEOUT_CYC  = 262128,
	parameter int unsigned SHORT_TIMEOUT_CYC = 8176
) (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// APB slave
	input  wire logic [wdtp_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Device modes and straps
	input  wire wdtp_pkg::wdtp_mode_t         mode,
	input  wire logic                         test_entry_voltage,
	input  wire logic                         reset_pin_function_enable,
	input  wire logic [7:0]                   reset_vector_low,
	// Reset outputs, open-drain reset pin
	output logic                              watchdog_reset,
	output logic                              reset_pin_out,
	output logic                              reset_pin_oe,
	// System event line
	output logic                              event_irq
);

	wdtp_pkg::wdtp_regs_t r;
	wdtp_pkg::wdtp_regs_t next_r;

	logic                          acc;
	logic                          setup;
	logic                          wr;
	logic [wdtp_pkg::IDX_W-1:0]    idx;
	logic                          aligned;
	logic                          mapped;
	logic                          disabled;
	logic [wdtp_pkg::CNT_W-1:0]    count;
	logic [wdtp_pkg::CNT_W-1:0]    limit;
	logic                          clear_hit;
	logic [wdtp_pkg::EVT_W-1:0]    evt_set;
	logic [wdtp_pkg::EVT_W-1:0]    evt_clr;
	logic [31:0]                   rd_mux;

	always_comb begin
		next_r = r;
		acc = psel & penable;
		setup = psel & ~penable;
		wr = acc & pwrite;
		idx = paddr[wdtp_pkg::ADDR_W-1:2];
		aligned = (paddr[1:0] == 2'h0);
		mapped = aligned & (idx == wdtp_pkg::CLEAR_IDX
			| idx == wdtp_pkg::CFG_IDX
			| idx == wdtp_pkg::CAUSE_IDX
			| idx == wdtp_pkg::EVT_IDX
			| idx == wdtp_pkg::EVT_CLR_IDX
			| idx == wdtp_pkg::EVT_EN_IDX);
		evt_set = '0;
		evt_clr = '0;

		// The test voltage comes from a pin and is synchronised first.
		next_r.tst_s1 = test_entry_voltage;
		next_r.tst_s2 = r.tst_s1;

		// The disable bit is read live every cycle.
		disabled = r.cfg_dis
			| (mode.monitor_mode & r.tst_s2)
			| (mode.monitor_mode & mode.break_active
				& mode.break_watchdog_disable);

		// One chained count: prescaler low, watchdog counter high.
		count = {r.wd, r.pre};
		limit = r.cfg_rate
			? wdtp_pkg::CNT_W'(SHORT_TIMEOUT_CYC - 1)
			: wdtp_pkg::CNT_W'(LONG_TIMEOUT_CYC - 1);

		// Any data counts as a service write.
		clear_hit = wr & aligned & (idx == wdtp_pkg::CLEAR_IDX);

		// Configuration takes one write, later ones are refused.
		if (wr & aligned & (idx == wdtp_pkg::CFG_IDX)) begin
			if (!r.cfg_lock) begin
				next_r.cfg_dis = pwdata[wdtp_pkg::CFG_DIS_BIT];
				next_r.cfg_rate = pwdata[wdtp_pkg::CFG_RATE_BIT];
				next_r.cfg_lock = 1'b1;
			end else begin
				evt_set[wdtp_pkg::EVT_REJECT_BIT] = 1'b1;
			end
		end
		if (wr & aligned & (idx == wdtp_pkg::EVT_CLR_IDX)) begin
			evt_clr = pwdata[wdtp_pkg::EVT_W-1:0];
		end
		if (wr & aligned & (idx == wdtp_pkg::EVT_EN_IDX)) begin
			next_r.evt_en = pwdata[wdtp_pkg::EVT_W-1:0];
		end

		case (r.state)
			wdtp_pkg::WDTP_POR: begin
				// Prescaler held clear until the power-up delay ends.
				next_r.pre = '0;
				next_r.wd = '0;
				next_r.por_cnt = r.por_cnt + 12'h001;
				if (r.por_cnt == 12'(wdtp_pkg::POR_CYC - 1)) begin
					next_r.state = wdtp_pkg::WDTP_RUN;
				end
			end
			wdtp_pkg::WDTP_RUN: begin
				if (mode.internal_reset) begin
					next_r.pre = '0;
					next_r.wd = '0;
					next_r.cfg_dis = wdtp_pkg::CFG_RST;
					next_r.cfg_rate = wdtp_pkg::CFG_RST;
					next_r.cfg_lock = wdtp_pkg::CFG_RST;
				end else if (disabled) begin
					next_r.pre = '0;
					next_r.wd = '0;
				end else if (mode.stop_mode | mode.stop_instr) begin
					// No clock reaches the counter in stop.
					next_r.pre = '0;
					if (clear_hit) begin
						next_r.wd = '0;
					end
				end else if (clear_hit) begin
					next_r.wd = '0;
					next_r.pre[wdtp_pkg::PRE_W-1:wdtp_pkg::PRE_CLR_LO]
						= '0;
				end else if (count == limit) begin
					// Timeout starts the reset, sets the cause flag and raises the timeout event.
					next_r.state = wdtp_pkg::WDTP_RST;
					next_r.rst_cnt = '0;
					next_r.cause_wd = 1'b1;
					evt_set[wdtp_pkg::EVT_TMO_BIT] = 1'b1;
				end else begin
					// Wait mode does not stop this path.
					{next_r.wd, next_r.pre} = count
						+ 18'h00001;
				end
			end
			wdtp_pkg::WDTP_RST: begin
				next_r.pre = '0;
				next_r.wd = '0;
				next_r.rst_cnt = r.rst_cnt + 5'h01;
				if (r.rst_cnt == 5'(wdtp_pkg::RST_HOLD_CYC - 1)) begin
					// Leaving the reset clears the configuration as an internal reset does.
					next_r.state = wdtp_pkg::WDTP_RUN;
					next_r.cfg_dis = wdtp_pkg::CFG_RST;
					next_r.cfg_rate = wdtp_pkg::CFG_RST;
					next_r.cfg_lock = wdtp_pkg::CFG_RST;
				end
			end
			default: begin
				next_r.state = wdtp_pkg::WDTP_POR;
			end
		endcase

		// Pin drive follows the state, gated by the pin function.
		next_r.pin_drive = (next_r.state == wdtp_pkg::WDTP_RST)
			& reset_pin_function_enable;

		// A new event wins over a clear in the same cycle.
		next_r.evt = (r.evt & ~evt_clr) | evt_set;

		rd_mux = 32'h0;
		if (aligned) begin
			case (idx)
				wdtp_pkg::CLEAR_IDX: begin
					// Reading the service port leaves counters alone.
					rd_mux[7:0] = reset_vector_low;
				end
				wdtp_pkg::CFG_IDX: begin
					rd_mux[wdtp_pkg::CFG_DIS_BIT] = r.cfg_dis;
					rd_mux[wdtp_pkg::CFG_RATE_BIT] = r.cfg_rate;
					rd_mux[wdtp_pkg::CFG_LOCK_BIT] = r.cfg_lock;
				end
				wdtp_pkg::CAUSE_IDX: begin
					rd_mux[wdtp_pkg::CAUSE_WD_BIT] = r.cause_wd;
				end
				wdtp_pkg::EVT_IDX: begin
					rd_mux[wdtp_pkg::EVT_W-1:0] = r.evt;
				end
				wdtp_pkg::EVT_EN_IDX: begin
					rd_mux[wdtp_pkg::EVT_W-1:0] = r.evt_en;
				end
				default: begin
					rd_mux = 32'h0;
				end
			endcase
		end
		// Read data is captured in the setup cycle, so no wait states.
		if (setup & ~pwrite) begin
			next_r.prdata = rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.state <= wdtp_pkg::WDTP_POR;
			r.pre <= '0;
			r.wd <= '0;
			r.rst_cnt <= '0;
			r.por_cnt <= '0;
			r.pin_drive <= 1'b0;
			r.cfg_dis <= wdtp_pkg::CFG_RST;
			r.cfg_rate <= wdtp_pkg::CFG_RST;
			r.cfg_lock <= wdtp_pkg::CFG_RST;
			r.cause_wd <= 1'b0;
			r.evt <= wdtp_pkg::EVT_RST;
			r.evt_en <= wdtp_pkg::EVT_RST;
			r.tst_s1 <= 1'b0;
			r.tst_s2 <= 1'b0;
			r.prdata <= 32'h0;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	assign watchdog_reset = (r.state == wdtp_pkg::WDTP_RST);
	// The pin is only ever pulled low; release is by the enable.
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = r.pin_drive;

	// This line reports to system logic only, never to the CPU.
	assign event_irq = |(r.evt & r.evt_en);

endmodule

// ---- tb/wdtp_monitor.sv ----
// Purpose: Port checker for the watchdog block.
// Assumes: One clock pclk and asynchronous active-low presetn.
// Notes:   Bound to wdtp_top below.
`timescale 1ns/1ns
module wdtp_monitor #(
	parameter int unsigned LONG_TIMEOUT_CYC  = 262128,
	parameter int unsigned SHORT_TIMEOUT_CYC = 8176
) (
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [17:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Reset pin and straps
	input wire logic        reset_pin_function_enable,
	input wire logic [7:0]  reset_vector_low,
	input wire logic        watchdog_reset,
	input wire logic        reset_pin_out,
	input wire logic        reset_pin_oe
);
	localparam logic [17:0] CLR_A = {wdtp_pkg::CLEAR_IDX, 2'h0};
	logic [5:0]  hi_cnt;
	logic [31:0] lo_cnt;
	// Pulse length and the gap between pulses are checked on counters.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt <= 6'h00;
			lo_cnt <= 32'h0;
		end else begin
			hi_cnt <= watchdog_reset ? hi_cnt + 6'h01 : 6'h00;
			lo_cnt <= watchdog_reset ? 32'h0 : lo_cnt + 32'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_hold; $fell(watchdog_reset) |-> hi_cnt == 6'h20; endproperty
	a_hold: assert property (p_hold) else $error("pulse length");
	property p_oe_in; reset_pin_oe |-> watchdog_reset; endproperty
	a_oe_in: assert property (p_oe_in) else $error("stray drive");
	property p_oe_en;
		watchdog_reset |-> reset_pin_oe == $past(reset_pin_function_enable);
	endproperty
	a_oe_en: assert property (p_oe_en) else $error("pin drive");
	property p_pin; reset_pin_out == 1'h0; endproperty
	a_pin: assert property (p_pin) else $error("pin level");
	property p_gap;
		$rose(watchdog_reset) |-> lo_cnt >= SHORT_TIMEOUT_CYC / 2;
	endproperty
	a_gap: assert property (p_gap) else $error("early timeout");
	property p_vec;
		psel && penable && !pwrite && paddr == CLR_A
			|-> prdata == {24'h0, $past(reset_vector_low)};
	endproperty
	a_vec: assert property (p_vec) else $error("clear read");
	property p_clr_ok;
		psel && penable && paddr == CLR_A |-> !pslverr;
	endproperty
	a_clr_ok: assert property (p_clr_ok) else $error("clear refused");
	property p_mis;
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
	endproperty
	a_mis: assert property (p_mis) else $error("misaligned accepted");
	c_to: cover property ($rose(watchdog_reset));
	c_err: cover property (psel && penable && pslverr);
	c_vec: cover property (psel && penable && paddr == CLR_A);
endmodule
bind wdtp_top wdtp_monitor #(
	.LONG_TIMEOUT_CYC(LONG_TIMEOUT_CYC),
	.SHORT_TIMEOUT_CYC(SHORT_TIMEOUT_CYC)
) u_monitor (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
	.reset_pin_function_enable(reset_pin_function_enable),
	.reset_vector_low(reset_vector_low), .watchdog_reset(watchdog_reset),
	.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe)
);

// ---- tb/tb_wdtp_top.sv ----
// Purpose: Self-checking bench of the watchdog block.
// Assumes: Timeouts shortened to 40 and 200 cycles.
// Notes:   Register cases run inside the power-up wait.
`timescale 1ns/1ns
module tb_wdtp_top;
	localparam int L = 200;
	localparam int S = 40;
	typedef struct {
		logic [17:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic [2:0]  f;
	} wdtp_row_t;
	logic                 pclk = 1'h0;
	logic                 presetn = 1'h0;
	logic                 psel = 1'h0;
	logic                 penable = 1'h0;
	logic                 pwrite = 1'h0;
	logic                 rpfe = 1'h1;
	logic                 tev = 1'h0;
	logic                 pready, pslverr, wd, oe, irq, e;
	logic [17:0]          paddr = 18'h0;
	logic [31:0]          pwdata = 32'h0;
	logic [31:0]          prdata, r;
	wdtp_pkg::wdtp_mode_t md = 6'h00;
	int                   mismatches = 0;
	int                   n_compared = 0;
	int                   cyc = 0;
	time                  t0, ts;
	// Flags: write, bus error, expected event line.
	wdtp_row_t            rows [14] = '{
		'{18'h00040, 32'h0, 32'h0, 3'h0}, '{18'h00044, 32'h0, 32'h0, 3'h0},
		'{18'h00050, 32'h3, 32'h0, 3'h4}, '{18'h00050, 32'h0, 32'h3, 3'h0},
		'{18'h00040, 32'h2, 32'h0, 3'h4}, '{18'h00040, 32'h0, 32'h6, 3'h0},
		'{18'h00040, 32'h1, 32'h0, 3'h5}, '{18'h00048, 32'h0, 32'h2, 3'h1},
		'{18'h0004C, 32'h0, 32'h0, 3'h1}, '{18'h0004C, 32'h2, 32'h0, 3'h4},
		'{18'h3FFFC, 32'h0, 32'hA5, 3'h0}, '{18'h3FFFC, 32'h0, 32'h0, 3'h4},
		'{18'h0003C, 32'h0, 32'h0, 3'h2}, '{18'h00041, 32'h0, 32'h0, 3'h2}};
	wdtp_top #(.LONG_TIMEOUT_CYC(L), .SHORT_TIMEOUT_CYC(S)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(md),
		.test_entry_voltage(tev), .reset_pin_function_enable(rpfe),
		.reset_vector_low(8'hA5), .watchdog_reset(wd), .reset_pin_out(),
		.reset_pin_oe(oe), .event_irq(irq));
	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 12000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk32(input string n, input logic [31:0] x, g);
		n_compared++;
		if (g !== x) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chkb(input string n, input logic x, g);
		chk32(n, {31'h0, x}, {31'h0, g});
	endtask
	task automatic apb(input logic [17:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wait_hi(input int m);
		for (int k = 0; k < m && wd !== 1'h1; k++) begin
			@(posedge pclk);
			#1;
		end
		ts = $time;
	endtask
	function automatic logic [31:0] edges(input time t);
		return 32'((ts - 1 - t) / 10);
	endfunction
	task automatic pulse(input logic eo);
		chkb("pin_drive", eo, oe);
		while (wd === 1'h1 && $time < ts + 1000) begin
			@(posedge pclk);
			#1;
		end
		chk32("hold", 32'h20, 32'(($time - ts) / 10));
	endtask
	task automatic no_rst(input int n);
		logic s;
		s = 1'h0;
		repeat (n) begin
			@(posedge pclk);
			#1;
			s = s | wd;
		end
		chkb("no_reset", 1'h0, s);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t0 = $time;
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].f[2], rows[i].d);
			#1;
			if (!rows[i].f[2]) chk32("rdata", rows[i].x, r);
			chkb("slverr", rows[i].f[1], e);
			chkb("event_irq", rows[i].f[0], irq);
		end
		wait_hi(5000);
		chk32("first_gap", 32'(4096 + S), edges(t0));
		pulse(1'h1);
		apb(18'h00044, 1'h0, 32'h0);
		chk32("cause", 32'h1, r);
		rpfe <= 1'h0;
		for (int k = 1; k < 7; k++) begin
			apb(18'h3FFFC, 1'h1, 32'(k) * 32'h2468ACE1);
			t0 = $time;
			no_rst(100);
		end
		wait_hi(L + 50);
		chkb("svc_gap", 1'h1, edges(t0) >= L - 16 && edges(t0) <= L);
		pulse(1'h0);
		apb(18'h00040, 1'h1, 32'h1);
		no_rst(3 * L);
		@(posedge pclk);
		md <= 6'h20;
		@(posedge pclk);
		md <= 6'h18;
		apb(18'h00040, 1'h0, 32'h0);
		chk32("cfg_cleared", 32'h0, r);
		no_rst(3 * L);
		@(posedge pclk);
		md <= 6'h04;
		tev <= 1'h1;
		no_rst(3 * L);
		@(posedge pclk);
		md <= 6'h07;
		tev <= 1'h0;
		no_rst(3 * L);
		@(posedge pclk);
		// Monitor mode and a break without the disable bit keep counting.
		md <= 6'h06;
		rpfe <= 1'h1;
		t0 = $time;
		wait_hi(L + 50);
		chkb("held", 1'h1, edges(t0) >= L - 2 && edges(t0) <= L + 3);
		pulse(1'h1);
		// Lone stop pulses must keep clearing a count that would expire.
		for (int k = 0; k < 6; k++) begin
			no_rst(90);
			@(posedge pclk);
			md <= 6'h0E;
			@(posedge pclk);
			md <= 6'h06;
		end
		chkb("timeout_event", 1'h1, irq);
		apb(18'h3FFFC, 1'h0, 32'h0);
		chk32("vector_read", 32'hA5, r);
		@(posedge pclk);
		presetn <= 1'h0;
		#1;
		chkb("rst_irq", 1'h0, irq);
		chkb("rst_drive", 1'h0, oe);
		chk32("rst_rdata", 32'h0, prdata);
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(18'h00044, 1'h0, 32'h0);
		chk32("cause_por", 32'h0, r);
		final_report();
	end
endmodule
